//--- por_seq_defs.vh
// Constants for the power-on reset sequencer: addresses, field positions, timing.
`ifndef POR_SEQ_DEFS_VH
`define POR_SEQ_DEFS_VH
`define ADDR_W            24
`define ADDR_STATUS       24'h40_0000
`define ADDR_CONTINUE     24'h40_0101
`define ADDR_CLOCK_RATIO  24'h60_0400
`define CLOCK_RATIO_FAST  64'h0083_F000_0000_0000
`define CLOCK_RATIO_RESET 64'h0000_0000_0000_0000
`define ST_PC_LSB         0
`define ST_DONE_BIT       8
`define ST_PHASE_LSB      12
`define ST_DEBUG_BIT      16
`define ST_FAST_BIT       17
`define ST_STATE_LSB      20
`define CLK_MHZ           250
`define SLOW_SCL_KHZ      50
`define FAST_SCL_KHZ      100
`define SLOW_SCL_HALF     ((`CLK_MHZ * 1000) / (2 * `SLOW_SCL_KHZ))
`define FAST_SCL_HALF     ((`CLK_MHZ * 1000) / (2 * `FAST_SCL_KHZ))
`define STEP_CYCLES       16
`endif

//--- step_unit.v
// Auxiliary step executor: runs one sequence instruction and reports completion.
`timescale 1ns/1ps
`default_nettype none
`include "por_seq_defs.vh"
module step_unit #(
	parameter CYCLES = `STEP_CYCLES
) (
	input  wire       clk,
	input  wire       resetn,
	input  wire       start,
	input  wire [3:0] opcode,
	output reg        done
);
	reg [15:0] count_q;
	reg        busy_q;

	// A WAIT opcode (0) never completes by itself; only a continue ends it.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_q <= 16'h0000;
			busy_q  <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy_q  <= (opcode != 4'h0);
				count_q <= CYCLES[15:0] + {12'h000, opcode};
			end else if (busy_q) begin
				if (count_q == 16'h0000) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
				end else begin
					count_q <= count_q - 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- power_on_reset_sequencer.v
// Power-on reset sequencer with register access over a scan-comm path.
`timescale 1ns/1ps
`default_nettype none
`include "por_seq_defs.vh"
// Function
// - Walk seven ordered boot phases zero to six.
// - Run fixed built-in instruction list after lock.
// - Record sequence progress in readable status register.
// - Normal mode advances without a continue except at WAIT steps.
// - Debug pin high at release pauses after every step not cut short by a continue.
// - Control through either I2C or JTAG port.
// - Slow serial clock until fast ratio value written.
// - Hard reset: reset sequencer, go token released.
// - Release clears counter, enters initial wait state.
// - A write to continue address advances in initial wait once locked, run or pause; ignored elsewhere.
// - Status shows counter and completion flag.
// - Debug wait needs two continues to pass.
module power_on_reset_sequencer #(
	parameter PROG_LEN = 25
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire        pllBypassN,
	input  wire        sequenceDebugPin,
	input  wire        linkClk,
	input  wire        i2cSel,
	input  wire        regWrite,
	input  wire        regRead,
	input  wire [23:0] regAddr,
	input  wire [63:0] regWdata,
	output reg  [63:0] regRdata,
	output reg         regRvalid,
	output wire        goTokenOut,
	output reg         goTokenOe,
	output reg         slowLink,
	output reg         pllLocked,
	output reg  [2:0]  bootPhases,
	output reg         sequenceDone,
	output reg  [15:0] sclHalfPeriod
);
	localparam S_WAIT0 = 3'd0;
	localparam S_LATCH = 3'd1;
	localparam S_DECODE = 3'd2;
	localparam S_GO = 3'd3;
	localparam S_RUN = 3'd4;
	localparam S_PAUSE = 3'd5;
	localparam S_END = 3'd6;
	localparam SLOW_HALF = `SLOW_SCL_HALF;
	localparam FAST_HALF = `FAST_SCL_HALF;

	// Built-in instruction list: low nibble opcode (0 is WAIT), bits 6:4 phase.
	function [6:0] program_word;
		input [4:0] pc;
		begin
			case (pc)
				5'd0, 5'd1, 5'd2:               program_word = {3'd0, 4'h1};
				5'd3, 5'd4, 5'd5, 5'd6:         program_word = {3'd1, 4'h2};
				5'd7, 5'd8, 5'd9:               program_word = {3'd1, 4'h3};
				5'd10:                          program_word = {3'd2, 4'h0};
				5'd11, 5'd12, 5'd13, 5'd14, 5'd15: program_word = {3'd3, 4'h4};
				5'd16:                          program_word = {3'd4, 4'h0};
				5'd17, 5'd18, 5'd19, 5'd20:     program_word = {3'd4, 4'h5};
				5'd21:                          program_word = {3'd5, 4'h0};
				default:                        program_word = {3'd6, 4'h6};
			endcase
		end
	endfunction

	// Pin and link inputs cross in through two flops before any logic reads them.
	// The synchronisers keep running through hard reset, so a debug pin held during
	// reset is already settled at the first edge after release, when the mode is taken.
	reg [1:0] dbgSync_q;
	reg [1:0] bypSync_q;
	reg [1:0] lclkSync_q;
	reg [1:0] selSync_q;
	reg       lclkPrev_q;
	always @(posedge clk) begin
		dbgSync_q  <= {dbgSync_q[0], sequenceDebugPin};
		bypSync_q  <= {bypSync_q[0], pllBypassN};
		lclkSync_q <= {lclkSync_q[0], linkClk};
		selSync_q  <= {selSync_q[0], i2cSel};
	end
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			lclkPrev_q <= 1'b0;
		else
			lclkPrev_q <= lclkSync_q[1];
	end
	wire linkRise = lclkSync_q[1] & ~lclkPrev_q;

	reg  [2:0]  state_q;
	reg  [4:0]  pc_q;
	reg         done_q;
	reg         debug_q;
	reg         modeTaken_q;
	reg  [1:0]  contCount_q;
	reg  [63:0] ratio_q;
	reg  [3:0]  opcode_q;
	reg         stepStart_q;
	reg  [7:0]  linkEdges_q;
	wire        stepDone;
	wire [6:0]  word = program_word(pc_q);

	// A continue is any write to the continue address, from either port.
	wire contCmd = regWrite && (regAddr == `ADDR_CONTINUE);
	wire ratioWr = regWrite && (regAddr == `ADDR_CLOCK_RATIO);
	wire fastLink = (ratio_q == `CLOCK_RATIO_FAST);

	step_unit #(
		.CYCLES (`STEP_CYCLES)
	) u_step (
		.clk    (clk),
		.resetn (resetn),
		.start  (stepStart_q),
		.opcode (opcode_q),
		.done   (stepDone)
	);

	// Resetn is the hard reset; it clears the machine and releases the token.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= S_WAIT0;
			pc_q        <= 5'd0;
			done_q      <= 1'b0;
			debug_q     <= 1'b0;
			modeTaken_q <= 1'b0;
			contCount_q <= 2'd0;
			opcode_q    <= 4'h0;
			stepStart_q <= 1'b0;
			ratio_q     <= `CLOCK_RATIO_RESET;
		end else begin
			stepStart_q <= 1'b0;
			if (!modeTaken_q) begin
				debug_q     <= dbgSync_q[1];
				modeTaken_q <= 1'b1;
			end
			// Continues seen since hard reset, saturating at two; the service unit may
			// only write the ratio once this reads two, so it is shown in status.
			if (contCmd && contCount_q != 2'd2)
				contCount_q <= contCount_q + 2'd1;
			if (ratioWr)
				ratio_q <= regWdata;
			case (state_q)
				S_WAIT0: begin
					// Normal mode leaves the initial wait by itself once the PLL is up.
					if (modeTaken_q && bypSync_q[1] && (!debug_q || contCmd))
						state_q <= S_LATCH;
				end
				S_LATCH: begin
					opcode_q <= word[3:0];
					done_q   <= 1'b0;
					state_q  <= S_DECODE;
				end
				S_DECODE: begin
					state_q <= S_GO;
				end
				S_GO: begin
					stepStart_q <= 1'b1;
					state_q     <= S_RUN;
				end
				S_RUN: begin
					if (stepDone || contCmd) begin
						done_q <= 1'b1;
						if (opcode_q == 4'h0 && debug_q)
							state_q <= S_PAUSE;
						else if (debug_q && !contCmd)
							state_q <= S_PAUSE;
						else if (pc_q == PROG_LEN[4:0] - 5'd1)
							state_q <= S_END;
						else begin
							pc_q    <= pc_q + 5'd1;
							state_q <= S_LATCH;
						end
					end
				end
				S_PAUSE: begin
					if (contCmd) begin
						if (pc_q == PROG_LEN[4:0] - 5'd1)
							state_q <= S_END;
						else begin
							pc_q    <= pc_q + 5'd1;
							state_q <= S_LATCH;
						end
					end
				end
				S_END: state_q <= S_END;
				default: state_q <= S_WAIT0;
			endcase
		end
	end

	// Status word: counter, completion, phase, mode, link speed, continues, state, link edges.
	wire [63:0] statusWord = {32'h0000_0000, linkEdges_q, 1'b0, state_q, contCount_q, fastLink, debug_q, 1'b0,
		word[6:4], 3'b000, done_q, 3'b000, pc_q};

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata      <= 64'h0000_0000_0000_0000;
			regRvalid     <= 1'b0;
			goTokenOe     <= 1'b0;
			slowLink      <= 1'b1;
			pllLocked     <= 1'b0;
			bootPhases    <= 3'd0;
			sequenceDone  <= 1'b0;
			sclHalfPeriod <= SLOW_HALF[15:0];
			linkEdges_q   <= 8'h00;
		end else begin
			regRvalid <= regRead;
			if (regRead) begin
				if (regAddr == `ADDR_STATUS)
					regRdata <= statusWord;
				else if (regAddr == `ADDR_CLOCK_RATIO)
					regRdata <= ratio_q;
				else
					regRdata <= 64'h0000_0000_0000_0000;
			end
			// Token pulled low while the I2C side is selected and the sequence has left the initial wait, else released.
			goTokenOe    <= selSync_q[1] && state_q != S_WAIT0;
			slowLink     <= !fastLink;
			sclHalfPeriod <= fastLink ? FAST_HALF[15:0] : SLOW_HALF[15:0];
			pllLocked    <= bypSync_q[1];
			bootPhases   <= word[6:4];
			sequenceDone <= (state_q == S_END);
			if (linkRise)
				linkEdges_q <= linkEdges_q + 8'h01;
		end
	end
	assign goTokenOut = 1'b0;
endmodule
`default_nettype wire

//--- power_on_reset_sequencer_assertions.sv
// Port checker for the power-on reset sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "por_seq_defs.vh"
module por_seq_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        regRead,
	input wire logic        regWrite,
	input wire logic [23:0] regAddr,
	input wire logic [63:0] regWdata,
	input wire logic [63:0] regRdata,
	input wire logic        regRvalid,
	input wire logic        goTokenOut,
	input wire logic        goTokenOe,
	input wire logic        slowLink,
	input wire logic        pllLocked,
	input wire logic [2:0]  bootPhases,
	input wire logic        sequenceDone,
	input wire logic [15:0] sclHalfPeriod
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence fastWrite;
		regWrite && regAddr == `ADDR_CLOCK_RATIO && regWdata == `CLOCK_RATIO_FAST;
	endsequence
	sequence spareRead;
		regRead && regAddr != `ADDR_STATUS && regAddr != `ADDR_CONTINUE && regAddr != `ADDR_CLOCK_RATIO;
	endsequence
	sequence ratioWrite;
		regWrite && regAddr == `ADDR_CLOCK_RATIO;
	endsequence
	sequence ratioRead;
		regRead && regAddr == `ADDR_CLOCK_RATIO;
	endsequence
	sequence statusRead;
		regRead && regAddr == `ADDR_STATUS;
	endsequence
	sequence heldReset;
		!resetn ##1 !resetn;
	endsequence
	a_read_answered: assert property (regRead |=> regRvalid) else $error("read not answered");
	a_valid_single: assert property (!regRead |=> !regRvalid) else $error("stray read valid");
	a_token_released: assert property (goTokenOut == 1'b0) else $error("token driven high");
	a_token_reset: assert property (@(posedge clk) disable iff (1'b0) heldReset |-> !goTokenOe)
		else $error("token driven during hard reset");
	a_phase_ordered: assert property (bootPhases <= 3'h6 && bootPhases >= $past(bootPhases))
		else $error("boot phase out of order");
	a_fast_lifts: assert property (fastWrite |-> ##[1:3] !slowLink && sclHalfPeriod == 16'h04E2)
		else $error("ratio write did not lift limit");
	a_slow_rate: assert property (slowLink [*2] |-> sclHalfPeriod == 16'h09C4) else $error("slow rate wrong");
	a_ratio_readback: assert property (ratioWrite ##1 !regWrite ##1 ratioRead |=> regRdata == $past(regWdata, 3))
		else $error("ratio read back wrong");
	a_status_shape: assert property (statusRead |=> regRdata[63:32] == 32'h0000_0000 && regRdata[4:0] <= 5'h18)
		else $error("status word out of range");
	a_spare_zero: assert property (spareRead |=> regRdata == 64'h0) else $error("unmapped read not zero");
	a_done_stays: assert property (sequenceDone |=> sequenceDone) else $error("done dropped");
	a_lock_first: assert property (!pllLocked |-> !sequenceDone) else $error("done without lock");
endmodule
bind power_on_reset_sequencer por_seq_checker chk (.clk, .resetn, .regRead, .regWrite, .regAddr, .regWdata,
	.regRdata, .regRvalid, .goTokenOut, .goTokenOe, .slowLink, .pllLocked, .bootPhases, .sequenceDone,
	.sclHalfPeriod);
`default_nettype wire

//--- service_unit_model.sv
// Service unit model: PLL bypass around hard reset and a framed link clock.
`timescale 1ns/1ps
`default_nettype none
module service_unit_model (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic frame,
	output var  logic pllBypassN,
	output var  logic linkClk
);
	initial linkClk = 0;
	// Bypass lifts well inside hard reset, so the lock is stable before release.
	always begin
		pllBypassN = 0;
		wait (resetn === 1'b0);
		repeat (4) @(posedge clk);
		#1 pllBypassN = 1;
		wait (resetn === 1'b1);
		wait (resetn === 1'b0);
	end
	// No edges leak out between frames.
	always #40 linkClk = frame ? ~linkClk : 1'b0;
endmodule
`default_nettype wire

//--- power_on_reset_sequencer_bench.sv
// Self-checking bench for the power-on reset sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "por_seq_defs.vh"
module power_on_reset_sequencer_bench;
	logic        clk = 0, resetn = 0, sequenceDebugPin = 0, i2cSel = 0, frame = 0;
	logic        regWrite = 0, regRead = 0;
	logic [23:0] regAddr = 0;
	logic [63:0] regWdata = 0, rdv, r;
	logic [7:0]  edges;
	wire  [63:0] regRdata;
	wire         regRvalid, goTokenOut, goTokenOe, slowLink, pllLocked, sequenceDone, pllBypassN, linkClk;
	wire  [2:0]  bootPhases;
	wire  [15:0] sclHalfPeriod;
	integer      n_fail = 0, checks = 0, seed = 32'h4a0c_d494, i, n10, ePc, eSt;
	always #2 clk = ~clk;
	service_unit_model SU (.clk, .resetn, .frame, .pllBypassN, .linkClk);
	power_on_reset_sequencer DUT (.clk, .resetn, .pllBypassN, .sequenceDebugPin, .linkClk, .i2cSel,
		.regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid, .goTokenOut, .goTokenOe,
		.slowLink, .pllLocked, .bootPhases, .sequenceDone, .sclHalfPeriod);
	task chk(input bit ok);
		checks++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED at %0t: mismatch", $time);
		end
	endtask
	task conclude;
		$display("checks %0d, failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wr(input [23:0] a, input [63:0] d);
		@(posedge clk);
		#1 regWrite = 1;
		regAddr = a;
		regWdata = d;
		@(posedge clk);
		#1 regWrite = 0;
	endtask
	task rd(input [23:0] a);
		@(posedge clk);
		#1 regRead = 1;
		regAddr = a;
		@(posedge clk);
		#1 regRead = 0;
		chk(regRvalid === 1'b1);
		rdv = regRdata;
	endtask
	task rst(input bit d);
		resetn = 0;
		sequenceDebugPin = d;
		repeat (12) @(posedge clk);
		chk(goTokenOe === 1'b0 && slowLink === 1'b1);
		#1 resetn = 1;
	endtask
	// In normal mode only the built-in WAIT steps hold the sequence until a continue arrives.
	function automatic bit isWait(input integer p);
		return p == 10 || p == 16 || p == 21;
	endfunction
	initial begin
		begin : run
			rst(0);
			frame = 1;
			rd(`ADDR_CLOCK_RATIO);
			chk(rdv === `CLOCK_RATIO_RESET);
			for (i = 0; i < 300 && sequenceDone !== 1'b1; i++) begin
				repeat (30) @(posedge clk);
				rd(`ADDR_STATUS);
				chk(rdv[22:20] !== 3'h5 && rdv[16] === 1'b0);
				if (rdv[22:20] === 3'h4 && isWait(rdv[4:0])) begin
					chk(rdv[8] === 1'b0);
					wr(`ADDR_CONTINUE, 64'h0000_0000_0000_0000);
				end
			end
			if (sequenceDone !== 1'b1) begin
				n_fail++;
				$display("CHECK FAILED at %0t: normal sequence timed out", $time);
				disable run;
			end
			rd(`ADDR_STATUS);
			chk(rdv[22:20] === 3'h6 && rdv[4:0] === 5'h18 && rdv[8] === 1'b1 && rdv[16] === 1'b0);
			chk(rdv[19:18] === 2'h2 && rdv[14:12] === 3'h6 && bootPhases === 3'h6);
			// The ratio is only touched once the second continue has gone out.
			for (i = 0; i < 8; i++) begin
				i2cSel = $random(seed);
				r = {$random(seed), $random(seed)};
				wr({8'h12, r[15:0]}, r);
				rd({8'h12, r[31:16]});
				chk(rdv === 64'h0000_0000_0000_0000 && goTokenOe === i2cSel);
				wr(`ADDR_CLOCK_RATIO, r);
				rd(`ADDR_CLOCK_RATIO);
				chk(rdv === r && slowLink === 1'b1);
			end
			wr(`ADDR_CLOCK_RATIO, `CLOCK_RATIO_FAST);
			rd(`ADDR_STATUS);
			chk(slowLink === 1'b0 && sclHalfPeriod === 16'h04E2 && rdv[17] === 1'b1);
			// One link clock period is twenty system clocks, so exactly one edge lands.
			edges = rdv[31:24];
			repeat (18) @(posedge clk);
			rd(`ADDR_STATUS);
			chk(rdv[31:24] - edges === 8'h01);
			i2cSel = 1;
			rst(1);
			// Dropping the pin after release must not leave debug mode.
			sequenceDebugPin = 0;
			repeat (200) @(posedge clk);
			rd(`ADDR_STATUS);
			chk(rdv[22:20] === 3'h0 && rdv[4:0] === 5'h00 && rdv[16] === 1'b1 && goTokenOe === 1'b0);
			n10 = 0;
			ePc = 0;
			eSt = 0;
			for (i = 0; i < 40 && sequenceDone !== 1'b1; i++) begin
				wr(`ADDR_CONTINUE, {$random(seed), $random(seed)});
				if (eSt == 5 && ePc == 24)
					eSt = 6;
				else if (eSt == 5) begin
					ePc++;
					eSt = isWait(ePc) ? 4 : 5;
				end else
					eSt = 5;
				repeat (60) @(posedge clk);
				rd(`ADDR_STATUS);
				chk(rdv[4:0] === ePc[4:0] && rdv[22:20] === eSt[2:0] && rdv[8] === (eSt != 4) && goTokenOe === 1'b1);
				n10 += (rdv[4:0] == 5'd10);
			end
			chk(sequenceDone === 1'b1 && n10 == 2 && rdv[19:18] === 2'h2);
		end
		conclude;
	end
endmodule
`default_nettype wire
